// *** llr_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "llr_params.svh"
// Notes on behaviour
// R1: Save log on disable entry and hourly
// R2: Count charges from below 15 to above 85
// R3: Count each further 10 percent charged
// R4: Count full shutdowns and disable entries
// R5: Keep peak charge and discharge current
// R6: Keep highest and lowest voltage per cell
// R7: Keep widest cell spread with cell ids
// R8: Keep highest and lowest pack temperature
// R9: Keep widest sensor spread with sensor ids
// R10: Add seconds to current temperature range total
// R11: Count balancing events per cell
// R12: Command 0x01 at 0x7ff8 clears log
// R13: Arm below low, count once above high
// R14: Range boundaries are configurable threshold inputs
module llr_top #(
  parameter int SEC_CYCLES = `LLR_SEC_CYC,
  parameter int HOUR_SECS  = `LLR_HOUR_S
) (
  input  wire logic                      clk_in,            // System clock, 20 MHz
  input  wire logic                      rst_n_in,          // Async reset, low
  input  wire logic                      ce_in,             // Clock enable
  input  wire logic                      cmd_wr_in,         // Command write strobe
  input  wire logic [15:0]               cmd_addr_in,       // Command address
  input  wire logic [7:0]                cmd_data_in,       // Command data
  input  wire logic                      disabled_in,       // Disabled mode level
  input  wire logic                      shutdown_in,       // Full shutdown pulse
  input  wire logic                      soc_valid_in,      // Charge state strobe
  input  wire llr_pkg::llr_soc_t         soc_in,            // Pack charge state, percent
  input  wire logic                      charging_in,       // Pack is charging
  input  wire logic                      cur_valid_in,      // Current strobe
  input  wire logic [15:0]               cur_in,            // Signed pack current, charge positive
  input  wire logic                      cell_valid_in,     // Cell voltage strobe
  input  wire logic [`LLR_CELL_IW-1:0]   cell_id_in,        // Cell index
  input  wire llr_pkg::llr_word_t        cell_v_in,         // Cell voltage
  input  wire logic                      temp_valid_in,     // Temperature strobe
  input  wire logic [`LLR_SENS_IW-1:0]   temp_id_in,        // Sensor index
  input  wire logic [15:0]               temp_in,           // Signed temperature
  input  wire logic [16*`LLR_NTHR-1:0]   temp_thr_in,       // Ascending signed range bounds
  input  wire logic [`LLR_NCELL-1:0]     bal_event_in,      // Per-cell balancing pulses
  output logic                           nvm_save_out,      // Save pulse to storage
  output logic                           log_clr_out,       // Clear in progress pulse
  output llr_pkg::llr_cnt_t              full_cycle_cnt_out,// Full charge cycles
  output llr_pkg::llr_cnt_t              step_cnt_out,      // Ten percent steps
  output llr_pkg::llr_cnt_t              shutdown_cnt_out,  // Shutdowns
  output logic [15:0]                    chg_max_out,       // Peak charge current
  output logic [15:0]                    dis_max_out,       // Peak discharge magnitude
  output logic [16*`LLR_NCELL-1:0]       cell_vmax_out,     // Per-cell highest voltage
  output logic [16*`LLR_NCELL-1:0]       cell_vmin_out,     // Per-cell lowest voltage
  output logic [15:0]                    vspread_out,       // Widest cell spread
  output logic [`LLR_CELL_IW-1:0]        vspread_hi_out,    // Higher cell of it
  output logic [`LLR_CELL_IW-1:0]        vspread_lo_out,    // Lower cell of it
  output logic [15:0]                    temp_max_out,      // Highest temperature
  output logic [15:0]                    temp_min_out,      // Lowest temperature
  output logic [15:0]                    tspread_out,       // Widest sensor spread
  output logic [`LLR_SENS_IW-1:0]        tspread_hi_out,    // Hotter sensor of it
  output logic [`LLR_SENS_IW-1:0]        tspread_lo_out,    // Colder sensor of it
  output logic [32*`LLR_NRANGE-1:0]      range_time_out,    // Seconds per range
  output logic [16*`LLR_NCELL-1:0]       bal_cnt_out        // Per-cell balancing counts
);

  // ==========================================================
  // Log clear command
  wire logic clr_hit;
  wire logic clr;
  assign clr_hit = cmd_wr_in && (cmd_addr_in == `LLR_CLR_ADDR) && (cmd_data_in == `LLR_CLR_VAL);
  assign clr     = log_clr_out;

  // Command bit sets on a hit and clears itself next cycle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      log_clr_out <= 1'b0;
    else if (ce_in)
      log_clr_out <= clr_hit; // [R12]
  end

  // ==========================================================
  // Second and hour timebase
  logic [31:0] sec_cnt_reg;
  logic [15:0] hour_cnt_reg;
  logic        dis_d_reg;
  wire logic   sec_tick;
  wire logic   hour_tick;
  wire logic   dis_rise;
  assign sec_tick  = (sec_cnt_reg == 32'(SEC_CYCLES - 1));
  assign hour_tick = sec_tick && (hour_cnt_reg == 16'(HOUR_SECS - 1));
  assign dis_rise  = disabled_in && !dis_d_reg;

  // Timebase counters, save strobe
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sec_cnt_reg  <= 32'h0000_0000;
      hour_cnt_reg <= 16'h0000;
      dis_d_reg    <= 1'b0;
      nvm_save_out <= 1'b0;
    end
    else if (ce_in)
    begin
      sec_cnt_reg  <= sec_tick ? 32'h0000_0000 : sec_cnt_reg + 32'h0000_0001;
      if (sec_tick)
        hour_cnt_reg <= hour_tick ? 16'h0000 : hour_cnt_reg + 16'h0001;
      dis_d_reg    <= disabled_in;
      nvm_save_out <= dis_rise || hour_tick; // [R1]
    end
  end

  // ==========================================================
  // Charge cycle and step counting
  logic             armed_reg;
  llr_pkg::llr_soc_t base_reg;
  wire logic        soc_low;
  wire logic        soc_high;
  wire logic        full_hit;
  wire logic        step_hit;
  wire logic [8:0]  step_lvl;
  assign soc_low  = soc_valid_in && (soc_in < `LLR_SOC_LOW);
  assign soc_high = soc_valid_in && charging_in && (soc_in > `LLR_SOC_HIGH);
  assign full_hit = armed_reg && soc_high && !soc_low;
  assign step_lvl = {1'b0, base_reg} + {1'b0, `LLR_SOC_STEP};
  assign step_hit = soc_valid_in && charging_in && ({1'b0, soc_in} >= step_lvl);

  // Arm, count, follow step baseline
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      armed_reg          <= 1'b0;
      base_reg           <= 8'h00;
      full_cycle_cnt_out <= `LLR_CNT_RST;
      step_cnt_out       <= `LLR_CNT_RST;
    end
    else if (ce_in)
    begin
      if (soc_low)
        armed_reg <= 1'b1; // [R13]
      else if (full_hit)
        armed_reg <= 1'b0; // [R13]
      if (soc_valid_in && (!charging_in || soc_in < base_reg))
        base_reg <= soc_in;
      else if (step_hit)
        base_reg <= step_lvl[7:0]; // [R3]
      if (clr)
      begin
        full_cycle_cnt_out <= `LLR_CNT_RST;
        step_cnt_out       <= `LLR_CNT_RST;
      end
      else
      begin
        if (full_hit)
          full_cycle_cnt_out <= full_cycle_cnt_out + 16'h0001; // [R2]
        if (step_hit)
          step_cnt_out <= step_cnt_out + 16'h0001; // [R3]
      end
    end
  end

  // ==========================================================
  // Shutdowns and peak currents
  wire logic        is_chg;
  wire logic [15:0] dis_mag;
  assign is_chg  = !cur_in[15];
  assign dis_mag = 16'(~cur_in + 16'h0001);

  // Shutdown counter and peak current holders
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      shutdown_cnt_out <= `LLR_CNT_RST;
      chg_max_out      <= `LLR_UMAX_RST;
      dis_max_out      <= `LLR_UMAX_RST;
    end
    else if (ce_in)
    begin
      if (clr)
      begin
        shutdown_cnt_out <= `LLR_CNT_RST;
        chg_max_out      <= `LLR_UMAX_RST;
        dis_max_out      <= `LLR_UMAX_RST;
      end
      else
      begin
        if (shutdown_in || dis_rise)
          shutdown_cnt_out <= shutdown_cnt_out + 16'h0001; // [R4]
        if (cur_valid_in && is_chg && cur_in > chg_max_out)
          chg_max_out <= cur_in; // [R5]
        if (cur_valid_in && !is_chg && dis_mag > dis_max_out)
          dis_max_out <= dis_mag; // [R5]
      end
    end
  end

  // ==========================================================
  // Per-cell voltage extremes and balancing counters
  genvar c;
  generate
    for (c = 0; c < `LLR_NCELL; c++)
    begin : g_cell
      llr_extreme #(.SIGNED_CMP(1'b0)) u_vext (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .clr_in   (clr),
        .valid_in (cell_valid_in && (int'(cell_id_in) == c)), // [R6]
        .value_in (cell_v_in),
        .max_out  (cell_vmax_out[16*c +: 16]),
        .min_out  (cell_vmin_out[16*c +: 16])
      );
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
          bal_cnt_out[16*c +: 16] <= `LLR_CNT_RST;
        else if (ce_in)
        begin
          if (clr)
            bal_cnt_out[16*c +: 16] <= `LLR_CNT_RST;
          else if (bal_event_in[c])
            bal_cnt_out[16*c +: 16] <= bal_cnt_out[16*c +: 16] + 16'h0001; // [R11]
        end
      end
    end
  endgenerate

  // Widest cell spread
  llr_spread #(.N(`LLR_NCELL), .IW(`LLR_CELL_IW)) u_vspread (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .ce_in        (ce_in),
    .clr_in       (clr),
    .valid_in     (cell_valid_in), // [R7]
    .id_in        (cell_id_in),
    .value_in     (cell_v_in),
    .spread_out   (vspread_out),
    .hi_id_out    (vspread_hi_out),
    .lo_id_out    (vspread_lo_out),
    .hi_now_out   (),
    .any_seen_out ()
  );

  // ==========================================================
  // Temperature extremes, spread and range time
  wire logic [15:0] temp_ofs;
  wire logic [15:0] hot_ofs;
  wire logic        temp_seen;
  assign temp_ofs = {~temp_in[15], temp_in[14:0]};

  // Pack extremes in signed order
  llr_extreme #(.SIGNED_CMP(1'b1)) u_text (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .clr_in   (clr),
    .valid_in (temp_valid_in), // [R8]
    .value_in (temp_in),
    .max_out  (temp_max_out),
    .min_out  (temp_min_out)
  );

  // Sensor spread on offset-coded values
  llr_spread #(.N(`LLR_NSENS), .IW(`LLR_SENS_IW)) u_tspread (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .ce_in        (ce_in),
    .clr_in       (clr),
    .valid_in     (temp_valid_in), // [R9]
    .id_in        (temp_id_in),
    .value_in     (temp_ofs),
    .spread_out   (tspread_out),
    .hi_id_out    (tspread_hi_out),
    .lo_id_out    (tspread_lo_out),
    .hi_now_out   (hot_ofs),
    .any_seen_out (temp_seen)
  );

  // Range index: bounds below the hottest sensor
  logic [1:0] range_idx;
  always_comb
  begin
    range_idx = 2'h0;
    for (int t = 0; t < `LLR_NTHR; t++)
      if (hot_ofs > {~temp_thr_in[16*t+15], temp_thr_in[16*t +: 15]})
        range_idx = range_idx + 2'h1; // [R14]
  end

  // One seconds total per range
  genvar r;
  generate
    for (r = 0; r < `LLR_NRANGE; r++)
    begin : g_range
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
          range_time_out[32*r +: 32] <= `LLR_TIME_RST;
        else if (ce_in)
        begin
          if (clr)
            range_time_out[32*r +: 32] <= `LLR_TIME_RST;
          else if (sec_tick && temp_seen && range_idx == 2'(r))
            range_time_out[32*r +: 32] <= range_time_out[32*r +: 32] + 32'h0000_0001; // [R10]
        end
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  a_clear_all: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R12]
    (ce_in && clr_hit) ##1 ce_in |=> (full_cycle_cnt_out == 16'h0000 && shutdown_cnt_out == 16'h0000
      && chg_max_out == 16'h0000 && (!log_clr_out || $past(clr_hit))))
    else $error("log clear left values");
  a_clear_self: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R12]
    log_clr_out && ce_in && !clr_hit |=> !log_clr_out)
    else $error("clear bit stuck");
  a_save_disable: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
    ce_in && disabled_in && !dis_d_reg |=> nvm_save_out)
    else $error("no save on disable entry");
  a_save_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
    $rose(nvm_save_out) |-> $past(dis_rise) || $past(hour_tick))
    else $error("save without cause");
  a_cycle_count: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R2]
    ce_in && full_hit && !clr |=> full_cycle_cnt_out == $past(full_cycle_cnt_out) + 16'h0001)
    else $error("full cycle not counted");
  a_cycle_rearm: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R13]
    ce_in && full_hit |=> !armed_reg ##0 (!full_hit || !ce_in))
    else $error("cycle counted twice");
  a_step_count: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
    ce_in && step_hit && !clr |=> step_cnt_out == $past(step_cnt_out) + 16'h0001)
    else $error("step not counted");
  a_shut_count: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R4]
    ce_in && !clr && (shutdown_in || dis_rise) |=> shutdown_cnt_out == $past(shutdown_cnt_out) + 16'h0001)
    else $error("shutdown not counted");
  a_chg_peak: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R5]
    ce_in && !clr && cur_valid_in && !cur_in[15] && cur_in > chg_max_out |=> chg_max_out == $past(cur_in))
    else $error("charge peak missed");
  a_bal_count: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R11]
    ce_in && !clr && bal_event_in[0] |=> bal_cnt_out[15:0] == $past(bal_cnt_out[15:0]) + 16'h0001)
    else $error("balancing not counted");
  a_freeze_state: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ce_in |=> $stable(step_cnt_out) && $stable(range_time_out))
    else $error("state moved while frozen");

  c_full_cycle: cover property (@(posedge clk_in) disable iff (!rst_n_in) ce_in && full_hit);
  c_hour_save:  cover property (@(posedge clk_in) disable iff (!rst_n_in) hour_tick && ce_in);
  c_clear:      cover property (@(posedge clk_in) disable iff (!rst_n_in) log_clr_out);
  c_vspread:    cover property (@(posedge clk_in) disable iff (!rst_n_in) $changed(vspread_out));
endmodule
`default_nettype wire

// *** llr_params.svh ***
`ifndef LLR_PARAMS_SVH
`define LLR_PARAMS_SVH

// ==========================================================
// Sizes
`define LLR_NCELL       16
`define LLR_CELL_IW     4
`define LLR_NSENS       4
`define LLR_SENS_IW     2
`define LLR_NRANGE      4
`define LLR_NTHR        3

// ==========================================================
// Command decode
`define LLR_CLR_ADDR    16'h7ff8
`define LLR_CLR_VAL     8'h01

// ==========================================================
// Charge thresholds in percent
`define LLR_SOC_LOW     8'h0f
`define LLR_SOC_HIGH    8'h55
`define LLR_SOC_STEP    8'h0a

// ==========================================================
// Reset values
`define LLR_CNT_RST     16'h0000
`define LLR_TIME_RST    32'h0000_0000
`define LLR_UMAX_RST    16'h0000
`define LLR_UMIN_RST    16'hffff
`define LLR_SMAX_RST    16'h8000
`define LLR_SMIN_RST    16'h7fff

// ==========================================================
// Timing: clock rate in Hz, hour in seconds
`define LLR_CLK_HZ      20000000
`define LLR_SEC_S       1
`define LLR_SEC_CYC     (`LLR_CLK_HZ * `LLR_SEC_S)
`define LLR_HOUR_S      3600

`endif

// *** llr_pkg.sv ***
`default_nettype none
package llr_pkg;
  // Sample, counter and time total types
  typedef logic [15:0] llr_word_t;
  typedef logic [15:0] llr_cnt_t;
  typedef logic [31:0] llr_time_t;
  typedef logic [7:0]  llr_soc_t;
endpackage
`default_nettype wire

// *** llr_extreme.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "llr_params.svh"
module llr_extreme #(
  parameter bit SIGNED_CMP = 1'b0
) (
  input  wire logic              clk_in,    // System clock
  input  wire logic              rst_n_in,  // Async reset, low
  input  wire logic              ce_in,     // Clock enable
  input  wire logic              clr_in,    // Log clear
  input  wire logic              valid_in,  // Sample strobe
  input  wire llr_pkg::llr_word_t value_in, // Sample
  output logic [15:0]            max_out,   // Highest seen
  output logic [15:0]            min_out    // Lowest seen
);
  localparam logic [15:0] MAX_RST = SIGNED_CMP ? `LLR_SMAX_RST : `LLR_UMAX_RST;
  localparam logic [15:0] MIN_RST = SIGNED_CMP ? `LLR_SMIN_RST : `LLR_UMIN_RST;

  // ==========================================================
  // Compare
  wire logic is_hi;
  wire logic is_lo;
  assign is_hi = SIGNED_CMP ? ($signed(value_in) > $signed(max_out)) : (value_in > max_out);
  assign is_lo = SIGNED_CMP ? ($signed(value_in) < $signed(min_out)) : (value_in < min_out);

  // Extremes update
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      max_out <= MAX_RST;
      min_out <= MIN_RST;
    end
    else if (ce_in)
    begin
      if (clr_in)
      begin
        max_out <= MAX_RST;
        min_out <= MIN_RST;
      end
      else if (valid_in)
      begin
        if (is_hi)
          max_out <= value_in;
        if (is_lo)
          min_out <= value_in;
      end
    end
  end
endmodule
`default_nettype wire

// *** llr_spread.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "llr_params.svh"
module llr_spread #(
  parameter int N  = `LLR_NCELL,
  parameter int IW = `LLR_CELL_IW
) (
  input  wire logic              clk_in,       // System clock
  input  wire logic              rst_n_in,     // Async reset, low
  input  wire logic              ce_in,        // Clock enable
  input  wire logic              clr_in,       // Log clear
  input  wire logic              valid_in,     // Sample strobe
  input  wire logic [IW-1:0]     id_in,        // Source index
  input  wire llr_pkg::llr_word_t value_in,    // Unsigned-ordered sample
  output logic [15:0]            spread_out,   // Largest spread
  output logic [IW-1:0]          hi_id_out,    // Upper source of it
  output logic [IW-1:0]          lo_id_out,    // Lower source of it
  output logic [15:0]            hi_now_out,   // Highest latest value
  output logic                   any_seen_out  // Any source sampled
);
  logic [15:0]   latest_reg [N];
  logic [N-1:0]  seen_reg;
  logic [15:0]   lo_now;
  logic [IW-1:0] hi_idx;
  logic [IW-1:0] lo_idx;
  logic          two_seen;

  // ==========================================================
  // Latest value per source
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_src
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
        begin
          latest_reg[g] <= 16'h0000;
          seen_reg[g]   <= 1'b0;
        end
        else if (ce_in)
        begin
          if (clr_in)
            seen_reg[g] <= 1'b0;
          else if (valid_in && (id_in == IW'(g)))
          begin
            latest_reg[g] <= value_in;
            seen_reg[g]   <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Scan for highest and lowest latest values
  always_comb
  begin
    logic found;
    found      = 1'b0;
    two_seen   = 1'b0;
    hi_now_out = 16'h0000;
    lo_now     = 16'h0000;
    hi_idx     = '0;
    lo_idx     = '0;
    for (int i = 0; i < N; i++)
    begin
      if (seen_reg[i])
      begin
        if (found)
          two_seen = 1'b1;
        if (!found || latest_reg[i] > hi_now_out)
        begin
          hi_now_out = latest_reg[i];
          hi_idx     = IW'(i);
        end
        if (!found || latest_reg[i] < lo_now)
        begin
          lo_now = latest_reg[i];
          lo_idx = IW'(i);
        end
        found = 1'b1;
      end
    end
  end

  wire logic [15:0] diff_now;
  wire logic        wider;
  assign diff_now     = hi_now_out - lo_now;
  assign wider        = two_seen && (diff_now > spread_out);
  assign any_seen_out = |seen_reg;

  // Record widest spread and its sources
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      spread_out <= 16'h0000;
      hi_id_out  <= '0;
      lo_id_out  <= '0;
    end
    else if (ce_in)
    begin
      if (clr_in)
      begin
        spread_out <= 16'h0000;
        hi_id_out  <= '0;
        lo_id_out  <= '0;
      end
      else if (wider)
      begin
        spread_out <= diff_now;
        hi_id_out  <= hi_idx;
        lo_id_out  <= lo_idx;
      end
    end
  end
endmodule
`default_nettype wire

// *** llr_host.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "llr_params.svh"
module llr_host (
  input  wire logic        clk_in,   // System clock
  input  wire logic        go_in,    // Issue one command
  input  wire logic [7:0]  data_in,  // Command data to send
  output logic             wr_out,   // Write strobe
  output logic [15:0]      addr_out, // Command address
  output logic [7:0]       dat_out   // Command data
);
  // ==========================================================
  // Idle bus shows a changing pattern, never the last value
  initial
  begin
    wr_out = 1'b0;
    addr_out = 16'h1234;
    dat_out = 8'h5a;
  end
  // One write per request, launched just after the edge
  always @(posedge clk_in)
  begin
    wr_out <= go_in;
    addr_out <= go_in ? `LLR_CLR_ADDR : ~addr_out;
    dat_out <= go_in ? data_in : ~dat_out;
  end
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic         clk_in, rst_n_in, ce_in, go, wr, dis, sdn, sv, chg, cv, lv, tv, nvm, clr;
  logic [7:0]   dat, cdat, soc;
  logic [15:0]  addr, cur, cellv, temp, fcc, stc, sdc, cmx, dmx, vsp, tmx, tmn, tsp, bal;
  logic [3:0]   cid, vhi, vlo;
  logic [1:0]   tid, thi, tlo;
  logic [255:0] vmxo, vmno, balo;
  logic [127:0] rto;
  int           err_count, tests_run, seed, fc, st, sd, base, mc, md, nsv, t0, i, j, k;
  int           vx[16], vn[16], bc[16];
  int           sq[8] = '{10, 90, 95, 50, 12, 97, 99, 14};
  bit           arm;

  llr_top #(.SEC_CYCLES(10), .HOUR_SECS(3)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .cmd_wr_in(wr), .cmd_addr_in(addr), .cmd_data_in(cdat), .disabled_in(dis), .shutdown_in(sdn),
    .soc_valid_in(sv), .soc_in(soc), .charging_in(chg), .cur_valid_in(cv), .cur_in(cur),
    .cell_valid_in(lv), .cell_id_in(cid), .cell_v_in(cellv), .temp_valid_in(tv), .temp_id_in(tid),
    .temp_in(temp), .temp_thr_in({16'h0050, 16'h0028, 16'h0000}), .bal_event_in(bal),
    .nvm_save_out(nvm), .log_clr_out(clr), .full_cycle_cnt_out(fcc), .step_cnt_out(stc),
    .shutdown_cnt_out(sdc), .chg_max_out(cmx), .dis_max_out(dmx), .cell_vmax_out(vmxo),
    .cell_vmin_out(vmno), .vspread_out(vsp), .vspread_hi_out(vhi), .vspread_lo_out(vlo),
    .temp_max_out(tmx), .temp_min_out(tmn), .tspread_out(tsp), .tspread_hi_out(thi),
    .tspread_lo_out(tlo), .range_time_out(rto), .bal_cnt_out(balo));
  llr_host i_host (.clk_in(clk_in), .go_in(go), .data_in(dat), .wr_out(wr), .addr_out(addr),
    .dat_out(cdat));

  // ==========================================================
  // Clock, watchdog and shared tasks
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial
  begin
    #100000;
    err_count++;
    give_verdict();
  end
  task automatic tk(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Charge sample with the reference cycle and step model
  task automatic put_soc(input int s, input bit c);
    soc = s[7:0];
    chg = c;
    sv = 1'b1;
    tk(1);
    sv = 1'b0;
    if (s < 15)
      arm = 1'b1;
    else if (s > 85 && c && arm)
      {fc, arm} = {fc + 1, 1'b0};
    if (!c || s < base)
      base = s;
    else if (s >= base + 10)
      {st, base} = {st + 1, base + 10};
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 32'h4b48dc97;
    {ce_in, go, dat, dis, sdn, sv, soc, chg, cv, cur, lv, cid, cellv, tv, tid, temp, bal} = '0;
    foreach (vn[j]) vn[j] = 65535;
    rst_n_in = 1'b0;
    tk(5);
    rst_n_in = 1'b1;
    ce_in = 1'b1;
    tk(1);
    chk("vmin0", vmno[255:240], 16'hffff);
    chk("tmin0", tmn, 16'h7fff);
    for (i = 0; i < 8; i++)
    begin
      put_soc(sq[i], i != 0);
      chk("fcyc", fcc, fc);
      chk("step", stc, st);
    end
    $display("Test charge counts done");
    // Random currents, cell voltages and balancing pulses
    for (i = 0; i < 40; i++)
    begin
      cur = $random(seed);
      cid = $random(seed);
      cellv = $random(seed);
      bal = $random(seed);
      {cv, lv} = 2'b11;
      tk(1);
      {cv, lv, bal[15:0]} = '0;
      k = $signed(cur);
      mc = (k > mc) ? k : mc;
      md = (-k > md) ? -k : md;
      vx[cid] = (cellv > vx[cid]) ? cellv : vx[cid];
      vn[cid] = (cellv < vn[cid]) ? cellv : vn[cid];
      chk("chgmax", cmx, mc);
      chk("dismax", dmx, md);
      chk("vmax", vmxo[cid*16 +: 16], vx[cid]);
      chk("vmin", vmno[cid*16 +: 16], vn[cid]);
    end
    $display("Test peaks done");
    // Balancing totals use the pulses applied above
    seed = 32'h4b48dc97;
    for (i = 0; i < 40; i++)
    begin
      k = $random(seed);
      k = $random(seed);
      k = $random(seed);
      k = $random(seed);
      foreach (bc[j]) bc[j] += k[j];
    end
    foreach (bc[j]) chk("bal", balo[j*16 +: 16], bc[j]);
    $display("Test balancing done");
    // Shutdown pulse, then disable entry with its save request
    sdn = 1'b1;
    tk(1);
    sdn = 1'b0;
    chk("sdn", sdc, 1);
    dis = 1'b1;
    tk(1);
    chk("save", nvm, 1'b1);
    chk("sdis", sdc, 2);
    dis = 1'b0;
    // Frozen clock enable drops a shutdown pulse
    {ce_in, sdn} = 2'b01;
    tk(3);
    {ce_in, sdn} = 2'b10;
    tk(1);
    chk("sfrz", sdc, 2);
    $display("Test shutdown done");
    // Wrong data is ignored, then a real clear
    for (i = 2; i > 0; i--)
    begin
      {go, dat} = {1'b1, i[7:0]};
      tk(1);
      go = 1'b0;
      tk(1);
      chk("clrp", clr, i == 1);
    end
    tk(1);
    chk("clr0", clr, 1'b0);
    chk("fclr", fcc, 0);
    chk("sclr", sdc, 0);
    chk("vclr", vmno[15:0], 16'hffff);
    $display("Test clear done");
    // Spreads after clear: two cells and two sensors
    {lv, cid, cellv, tv, tid, temp} = {1'b1, 4'h3, 16'h03e8, 1'b1, 2'h1, 16'h0032};
    tk(1);
    {cid, cellv, tid, temp} = {4'h5, 16'h0190, 2'h2, 16'hfff6};
    tk(1);
    {lv, tv} = 2'b00;
    tk(1);
    chk("vsp", {vsp, vhi, vlo}, {16'h0258, 4'h3, 4'h5});
    chk("tsp", {tsp, thi, tlo}, {16'h003c, 2'h1, 2'h2});
    chk("tmm", {tmx, tmn}, {16'h0032, 16'hfff6});
    $display("Test spreads done");
    // Time in range two and hourly saves over nine seconds
    t0 = rto[95:64];
    nsv = 0;
    for (i = 0; i < 90; i++)
    begin
      tk(1);
      nsv += nvm;
    end
    chk("range", rto[95:64] - t0, 9);
    chk("range0", rto[31:0], 0);
    chk("hour", nsv, 3);
    $display("Test time done");
    give_verdict();
  end
endmodule
`default_nettype wire
